// ==== src/clock_monitor_pkg.sv ====
/*
 * Shared constants, types and register map of the DSI clock frequency monitor.
 * Assumes a 20 MHz system clock and an Avalon-MM slave with byte addresses.
 */
`default_nettype none

package clock_monitor_pkg;

	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int SYS_CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;

	// Stability times, then their least cycle counts, rounded up.
	localparam int STABLE_T0_US = 40;
	localparam int STABLE_T1_US = 80;
	localparam int STABLE_T2_US = 320;
	localparam int STABLE_T3_US = 1280;
	localparam int STABLE_T0_CYC = (STABLE_T0_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int STABLE_T1_CYC = (STABLE_T1_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int STABLE_T2_CYC = (STABLE_T2_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int STABLE_T3_CYC = (STABLE_T3_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

	// Measurement window; edges counted over it divided by its length in us give MHz.
	localparam int MEAS_WINDOW_US = 8;
	localparam int MEAS_WINDOW_CYC = (MEAS_WINDOW_US * 1000) / SYS_CLK_PERIOD_NS;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_CTRL = 8'h5C;
	localparam logic [7:0] IDX_LOW_LIMIT = 8'h5D;
	localparam logic [7:0] IDX_HIGH_LIMIT = 8'h5E;
	localparam logic [7:0] IDX_PIXEL_RATE = 8'h5F;
	localparam logic [7:0] IDX_MODE = 8'h70;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h71;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h72;
	localparam logic [7:0] IDX_DET_STATUS = 8'h73;

	localparam logic [7:0] LOW_LIMIT_RST = 8'h06;
	localparam logic [7:0] HIGH_LIMIT_RST = 8'h2C;
	localparam logic [7:0] CTRL_RST = 8'h07;
	localparam logic [7:0] HIGH_LIMIT_MASK = 8'h7F;

	localparam int LOW_POLICY_BIT = 7;
	localparam int LOW_PHY_RST_MODE_BIT = 6;
	localparam int CTRL_FORCE_BIT = 5;
	localparam int CTRL_STBL_LSB = 3;
	localparam int CTRL_BAND_LSB = 0;

	localparam int IRQ_W = 3;
	localparam int IRQ_VALID_RISE = 0;
	localparam int IRQ_VALID_FALL = 1;
	localparam int IRQ_CAPTURE = 2;

	typedef enum logic [1:0] {
		MODE_SINGLE_DSI,
		MODE_DUAL_DSI,
		MODE_SPLITTER,
		MODE_REF_CLOCK
	} op_mode_t;

	typedef enum logic [1:0] {
		DET_IDLE,
		DET_TRACK,
		DET_STABLE
	} det_state_t;

	typedef struct packed {
		logic done;
		logic [7:0] mhz;
	} meas_t;

endpackage

`default_nettype wire

// ==== src/dsi_clock_rate_counter.sv ====
/*
 * Counts rising edges of the DSI clock over a fixed window of the system clock.
 * Assumes the DSI clock is slower than half the system clock; it is sampled, not used as a clock.
 */
`default_nettype none

module dsi_clock_rate_counter
	import clock_monitor_pkg::*;
#(
	parameter int WINDOW_CYC = MEAS_WINDOW_CYC,
	parameter int WINDOW_US = MEAS_WINDOW_US
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_dsi_clk,
	output var meas_t o_meas
);

	localparam int SHIFT = $clog2(WINDOW_US);
	localparam int CW = $clog2(WINDOW_CYC + 1);

	if (WINDOW_US < 1 || (1 << SHIFT) != WINDOW_US || WINDOW_CYC < 2) begin : g_bad_window
		$error("Window length must be a power of two in us and span two cycles.");
	end

	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic [CW-1:0] win_q;
	logic [CW-1:0] edges_q;
	logic [CW-1:0] rate;
	logic rise;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			sync1_q <= i_dsi_clk;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	assign rise = sync2_q & ~prev_q;
	assign rate = edges_q >> SHIFT;

	// Edges per window over the window in us gives whole MHz.
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			win_q <= '0;
			edges_q <= '0;
			o_meas <= '0;
		end else begin
			o_meas.done <= 1'b0;
			if (win_q == CW'(WINDOW_CYC - 1)) begin
				win_q <= '0;
				edges_q <= CW'(rise);
				o_meas.done <= 1'b1;
				o_meas.mhz <= (rate > CW'(255)) ? 8'hFF : 8'(rate);
			end else begin
				win_q <= win_q + CW'(1);
				edges_q <= edges_q + CW'(rise);
			end
		end
	end

endmodule

`default_nettype wire

// ==== src/dsi_clock_frequency_monitor.sv ====
/*
 * DSI clock frequency monitor: measurement hysteresis, stability timing, limit checks,
 * pixel-rate reporting, receive PHY reset request, interrupts and an Avalon-MM register slave.
 * Assumes the DSI clock arrives asynchronously and that the forwarding and splitter rates
 * come from logic on the system clock.
 */
// The Avalon-MM slave port was left to the implementer.
`default_nettype none


module dsi_clock_frequency_monitor
	import clock_monitor_pkg::*;
#(
	parameter int STABLE_320_CYC = STABLE_T2_CYC,
	parameter int STABLE_1280_CYC = STABLE_T3_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_dsi_clk,
	input wire logic [7:0] i_forward_rate_mhz,
	input wire logic [7:0] i_splitter_rate_mhz,
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq,
	output logic o_dsi_phy_reset,
	output logic o_clock_present,
	output logic [7:0] o_measured_pixel_rate_mhz
);

	localparam int SW = $clog2(STABLE_1280_CYC + 1);

	if (STABLE_320_CYC < STABLE_T1_CYC || STABLE_1280_CYC < STABLE_320_CYC) begin : g_bad_stable
		$error("Stability counts must not fall below the shorter settings.");
	end

	meas_t meas;

	logic [7:0] low_q;
	logic [7:0] high_q;
	logic [7:0] ctrl_q;
	op_mode_t mode_q;
	op_mode_t mode_prev_q;
	logic [IRQ_W-1:0] irq_status_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_event;
	logic [IRQ_W-1:0] irq_clear;

	det_state_t state_q;
	logic [7:0] saved_q;
	logic [SW-1:0] stable_cnt_q;
	logic [SW-1:0] stable_thr;
	logic capture;
	logic out_of_band;
	logic [7:0] diff;
	logic meas_zero;
	logic meas_new;
	logic valid;
	logic valid_prev_q;
	logic [7:0] rate_q;
	logic phy_reset_q;
	logic phy_req;

	logic ack_q;
	logic [31:0] readdata_q;
	logic [7:0] index;
	logic addr_ok;
	logic wr_fire;
	logic wr_lane0;
	logic rd_take;
	logic [31:0] det_word;

	dsi_clock_rate_counter #(
		.WINDOW_CYC(MEAS_WINDOW_CYC),
		.WINDOW_US(MEAS_WINDOW_US)
	) u_rate_counter (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_dsi_clk(i_dsi_clk),
		.o_meas(meas)
	);

	function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
		abs_diff = (a > b) ? (a - b) : (b - a);
	endfunction

	function automatic logic [7:0] reg_byte(input logic [31:0] d);
		reg_byte = d[7:0];
	endfunction

	function automatic logic ctrl_low_policy();
		ctrl_low_policy = low_q[LOW_POLICY_BIT];
	endfunction

	// Both limits are inclusive; the reserved high bit never widens the window.
	function automatic logic in_limits(input logic [7:0] f, input logic [7:0] lo,
		input logic [7:0] hi);
		in_limits = f >= {2'b00, lo[5:0]} && f <= (hi & HIGH_LIMIT_MASK);
	endfunction

	// Doubling saturates, so a very fast dual input reads as the ceiling and not as a small value.
	function automatic logic [7:0] double_sat(input logic [7:0] r);
		double_sat = r[7] ? 8'hFF : {r[6:0], 1'b0};
	endfunction

	// Bus decode: one wait state, then the answer stands for one cycle.

	assign index = i_avs_address[9:2];
	assign addr_ok = (i_avs_address[1:0] == 2'h0);
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
	assign wr_fire = i_avs_write & ack_q & addr_ok;
	assign wr_lane0 = wr_fire & i_avs_byteenable[0];
	assign o_avs_readdata = readdata_q;
	assign rd_take = i_avs_read & ~ack_q & addr_ok;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			readdata_q <= 32'h0000_0000;
		end else if (rd_take) begin
			unique case (index)
				IDX_CTRL: readdata_q <= {24'h00_0000, ctrl_q};
				IDX_LOW_LIMIT: readdata_q <= {24'h00_0000, low_q};
				IDX_HIGH_LIMIT: readdata_q <= {24'h00_0000, high_q & HIGH_LIMIT_MASK};
				IDX_PIXEL_RATE: readdata_q <= {24'h00_0000, rate_q};
				IDX_MODE: readdata_q <= {30'h0000_0000, mode_q};
				IDX_IRQ_STATUS: readdata_q <= {{(32 - IRQ_W){1'b0}}, irq_status_q};
				IDX_IRQ_MASK: readdata_q <= {{(32 - IRQ_W){1'b0}}, irq_mask_q};
				IDX_DET_STATUS: readdata_q <= det_word;
				default: readdata_q <= 32'h0000_0000;
			endcase
		end else begin
			readdata_q <= 32'h0000_0000;
		end
	end

	// Detector status: saved frequency in the second byte, state flags in the first.
	always_comb begin
		det_word = 32'h0000_0000;
		det_word[15:8] = saved_q;
		det_word[2] = state_q == DET_STABLE;
		det_word[1] = state_q != DET_IDLE;
		det_word[0] = valid;
	end

	// Software-written controls.

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			low_q <= LOW_LIMIT_RST;
			high_q <= HIGH_LIMIT_RST;
			ctrl_q <= CTRL_RST;
			mode_q <= MODE_SINGLE_DSI;
			irq_mask_q <= '0;
		end else if (wr_lane0) begin
			unique case (index)
				IDX_CTRL: ctrl_q <= reg_byte(i_avs_writedata) & 8'h3F;
				IDX_LOW_LIMIT: low_q <= reg_byte(i_avs_writedata);
				IDX_HIGH_LIMIT: high_q <= reg_byte(i_avs_writedata) & HIGH_LIMIT_MASK;
				IDX_MODE: mode_q <= op_mode_t'(i_avs_writedata[1:0]);
				IDX_IRQ_MASK: irq_mask_q <= i_avs_writedata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Stability threshold from the two-bit select code.
	// The count restarts at every capture, so a clock that keeps leaving the band never turns stable.

	always_comb begin
		unique case (ctrl_q[CTRL_STBL_LSB +: 2])
			2'h0: stable_thr = SW'(STABLE_T0_CYC);
			2'h1: stable_thr = SW'(STABLE_T1_CYC);
			2'h2: stable_thr = SW'(STABLE_320_CYC);
			2'h3: stable_thr = SW'(STABLE_1280_CYC);
		endcase
	end

	assign diff = abs_diff(meas.mhz, saved_q);
	assign out_of_band = diff > {5'h00, ctrl_q[CTRL_BAND_LSB +: 3]};
	assign meas_zero = meas.done && meas.mhz == 8'h00;
	assign meas_new = meas.done && meas.mhz != 8'h00;

	// Frequency tracking and stability.
	// A zero window means the clock stopped; idle makes the next start a fresh capture.

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_q <= DET_IDLE;
			saved_q <= 8'h00;
			stable_cnt_q <= '0;
			capture <= 1'b0;
		end else begin
			capture <= 1'b0;
			unique case (state_q)
				DET_IDLE: begin
					stable_cnt_q <= '0;
					if (meas_new) begin
						saved_q <= meas.mhz;
						capture <= 1'b1;
						state_q <= DET_TRACK;
					end
				end
				DET_TRACK: begin
					if (meas_zero) begin
						saved_q <= 8'h00;
						capture <= 1'b1;
						state_q <= DET_IDLE;
					end else if (meas.done && out_of_band) begin
						saved_q <= meas.mhz;
						capture <= 1'b1;
						stable_cnt_q <= '0;
					end else begin
						if (meas.done && !ctrl_low_policy()) begin
							saved_q <= meas.mhz;
						end
						// With the legacy policy the first value is held.
						if (stable_cnt_q + SW'(1) >= stable_thr) begin
							state_q <= DET_STABLE;
						end else begin
							stable_cnt_q <= stable_cnt_q + SW'(1);
						end
					end
				end
				DET_STABLE: begin
					if (meas_zero) begin
						saved_q <= 8'h00;
						capture <= 1'b1;
						state_q <= DET_IDLE;
					end else if (meas.done && out_of_band) begin
						saved_q <= meas.mhz;
						capture <= 1'b1;
						stable_cnt_q <= '0;
						state_q <= DET_TRACK;
					end
				end
				default: state_q <= DET_IDLE;
			endcase
		end
	end

	// Forcing bypasses the detector; otherwise stable and inside both limits.
	always_comb begin
		valid = 1'b0;
		if (ctrl_q[CTRL_FORCE_BIT]) begin
			valid = 1'b1;
		end else if (state_q == DET_STABLE) begin
			valid = in_limits(saved_q, low_q, high_q);
		end
	end
	assign o_clock_present = valid;

	// Reported pixel rate. The doubled dual rate saturates rather than wrapping.

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			rate_q <= 8'h00;
		end else begin
			unique case (mode_q)
				MODE_REF_CLOCK: rate_q <= i_forward_rate_mhz;
				MODE_SPLITTER: rate_q <= valid ? i_splitter_rate_mhz : 8'h00;
				MODE_DUAL_DSI: rate_q <= valid ? double_sat(saved_q) : 8'h00;
				MODE_SINGLE_DSI: rate_q <= valid ? saved_q : 8'h00;
			endcase
		end
	end
	assign o_measured_pixel_rate_mhz = rate_q;

	// PHY reset pulse on a mode change or a captured frequency.
	// The request is registered so that the PHY sees a clean pulse with no decode glitches.
	assign phy_req = capture | (mode_q != mode_prev_q);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			mode_prev_q <= MODE_SINGLE_DSI;
			phy_reset_q <= 1'b0;
		end else begin
			mode_prev_q <= mode_q;
			phy_reset_q <= !low_q[LOW_PHY_RST_MODE_BIT] && phy_req;
		end
	end
	assign o_dsi_phy_reset = phy_reset_q;

	// Interrupts: sticky, write one to clear, a new event wins over the clear.

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			valid_prev_q <= 1'b0;
		end else begin
			valid_prev_q <= valid;
		end
	end

	always_comb begin
		irq_event = '0;
		irq_event[IRQ_VALID_RISE] = valid & ~valid_prev_q;
		irq_event[IRQ_VALID_FALL] = ~valid & valid_prev_q;
		irq_event[IRQ_CAPTURE] = capture;
	end

	always_comb begin
		irq_clear = '0;
		if (wr_lane0 && index == IDX_IRQ_STATUS) begin
			irq_clear = i_avs_writedata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
		end
	end

	assign o_irq = |(irq_status_q & irq_mask_q);

endmodule

`default_nettype wire

// ==== verif/clock_monitor_props.sv ====
/*
 * Checker of the monitor's register bus, reset values and pulse outputs.
 * Assumes a master that holds each request until waitrequest is low.
 */
`default_nettype none

module clock_monitor_props
	import clock_monitor_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [9:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic o_irq,
	input wire logic o_dsi_phy_reset,
	input wire logic o_clock_present,
	input wire logic [7:0] o_measured_pixel_rate_mhz
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	wire logic req = i_avs_read | i_avs_write;
	wait_state_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("request not answered after one wait state");
	back_to_back_a: assert property (req && !o_avs_waitrequest ##1 req |-> o_avs_waitrequest)
		else $error("second request answered without a wait state");
	idle_bus_a: assert property (!req |-> !o_avs_waitrequest)
		else $error("waitrequest high with no request");
	read_zero_a: assert property (!(i_avs_read && !o_avs_waitrequest) |-> o_avs_readdata == 0)
		else $error("read data not zero outside a read answer");
	high_reserved_a: assert property (i_avs_read && !o_avs_waitrequest &&
		i_avs_address == {IDX_HIGH_LIMIT, 2'b00} |-> o_avs_readdata[31:7] == 0)
		else $error("reserved high limit bit reads nonzero");
	upper_zero_a: assert property (o_avs_readdata[31:16] == 0)
		else $error("read data upper bits nonzero");
	phy_pulse_a: assert property (o_dsi_phy_reset |=> !o_dsi_phy_reset)
		else $error("phy reset longer than one cycle");
	reset_values_a: assert property ($fell(i_rst) |-> !o_irq && !o_clock_present &&
		!o_dsi_phy_reset && o_measured_pixel_rate_mhz == 0)
		else $error("outputs not cleared by reset");
endmodule

bind dsi_clock_frequency_monitor clock_monitor_props i_clock_monitor_props (.i_sys_clk,
	.i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
	.o_irq, .o_dsi_phy_reset, .o_clock_present, .o_measured_pixel_rate_mhz);

`default_nettype wire

// ==== verif/dsi_lane_source.sv ====
/*
 * Far-side model: the video source's DSI clock at 2.5 MHz.
 * Assumes the bench gates it; the clock stands low while disabled.
 */
`default_nettype none

module dsi_lane_source (
	input wire logic i_en,
	output logic o_dsi_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_dsi_clk = 1'b0;
	// Half period of 200 ns; every edge falls on a falling edge of the system clock.
	always begin
		#200;
		o_dsi_clk = i_en ? ~o_dsi_clk : 1'b0;
	end
endmodule

`default_nettype wire

// ==== verif/test_dsi_clock_frequency_monitor.sv ====
/*
 * Bench of the monitor: Avalon register tests with a gated DSI clock source.
 * Assumes one wait state per access and shortened stability counts.
 */
`default_nettype none

module test_dsi_clock_frequency_monitor;
	import clock_monitor_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 0, i_rst = 1, dsi_en = 0, avs_read = 0, avs_write = 0;
	logic [9:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, readdata, rd;
	logic waitreq, irq, phy_reset, present;
	logic [7:0] rate;
	wire logic dsi_clk;
	int bad_count = 0, check_count = 0, cycles = 0, phy_count = 0;

	always #25 i_sys_clk = ~i_sys_clk;
	dsi_lane_source i_dsi_lane_source (.i_en(dsi_en), .o_dsi_clk(dsi_clk));
	dsi_clock_frequency_monitor #(.STABLE_320_CYC(1600), .STABLE_1280_CYC(1600))
		i_dsi_clock_frequency_monitor (.i_sys_clk, .i_rst, .i_dsi_clk(dsi_clk),
		.i_forward_rate_mhz(8'h5A), .i_splitter_rate_mhz(8'h33), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.i_avs_byteenable(4'hF), .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq),
		.o_irq(irq), .o_dsi_phy_reset(phy_reset), .o_clock_present(present),
		.o_measured_pixel_rate_mhz(rate));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge i_sys_clk) begin
		cycles++;
		if (phy_reset === 1'b1)
			phy_count++;
		if (cycles > 40000) begin
			bad_count++;
			end_sim();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Strobes change just after a rising edge and stand until waitrequest is seen low there.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h00_0000, wd};
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge i_sys_clk);
		while (waitreq !== 1'b0) begin
			@(posedge i_sys_clk);
			n++;
		end
		chk("bus wait states", 32'h1, n);
		rd = readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Two reads back to back: read stays high and only the address moves on at the answer.
	task automatic rd_two(input string name, input logic [7:0] ia, input logic [31:0] ea,
		input logic [7:0] ib, input logic [31:0] eb);
		@(posedge i_sys_clk);
		avs_address <= {ia, 2'b00};
		avs_read <= 1'b1;
		@(posedge i_sys_clk);
		while (waitreq !== 1'b0) @(posedge i_sys_clk);
		chk(name, ea, readdata);
		avs_address <= {ib, 2'b00};
		@(posedge i_sys_clk);
		while (waitreq !== 1'b0) @(posedge i_sys_clk);
		chk(name, eb, readdata);
		avs_read <= 1'b0;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
		bus(0, idx, 8'h00);
		chk(name, exp, rd);
	endtask

	task automatic wait_present(input logic exp);
		int n;
		n = 0;
		while (present !== exp && n < 4000) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk("clock present", exp, present);
	endtask

	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 0;
		rd_chk("low limit", IDX_LOW_LIMIT, 32'h06);
		rd_chk("high limit", IDX_HIGH_LIMIT, 32'h2C);
		rd_two("ctrl then mode", IDX_CTRL, 32'h07, IDX_MODE, 32'h00);
		rd_chk("rate", IDX_PIXEL_RATE, 32'h00);
		bus(1, IDX_HIGH_LIMIT, 8'hFF);
		rd_chk("high limit", IDX_HIGH_LIMIT, 32'h7F);
		bus(1, IDX_HIGH_LIMIT, 8'h2C);
		bus(1, IDX_LOW_LIMIT, 8'h02);
		rd_chk("low limit", IDX_LOW_LIMIT, 32'h02);
		bus(1, IDX_PIXEL_RATE, 8'h55);
		rd_chk("rate", IDX_PIXEL_RATE, 32'h00);
		rd_chk("unmapped", 8'h40, 32'h00);
		$display("test registers done");
		repeat (400) @(posedge i_sys_clk);
		rd_chk("rate", IDX_PIXEL_RATE, 32'h00);
		bus(1, IDX_MODE, 8'h03);
		rd_chk("rate", IDX_PIXEL_RATE, 32'h5A);
		bus(1, IDX_MODE, 8'h00);
		bus(1, IDX_IRQ_MASK, 8'h07);
		$display("test idle done");
		// A 2.5 MHz clock gives 20 edges per 8 us window, hence 2 MHz.
		@(posedge i_sys_clk);
		phy_count = 0;
		dsi_en <= 1;
		wait_present(1);
		chk("phy resets", 1, phy_count > 0);
		@(negedge i_sys_clk);
		chk("rate port", 8'h02, rate);
		chk("lane rate one lane", 32'h30, 32'(rate) * 32'h18);
		chk("irq", 1, irq);
		rd_chk("irq status", IDX_IRQ_STATUS, 32'h05);
		bus(1, IDX_IRQ_STATUS, 8'h07);
		@(negedge i_sys_clk);
		chk("irq", 0, irq);
		bus(1, IDX_MODE, 8'h01);
		rd_chk("rate", IDX_PIXEL_RATE, 32'h04);
		bus(1, IDX_MODE, 8'h02);
		rd_chk("rate", IDX_PIXEL_RATE, 32'h33);
		bus(1, IDX_MODE, 8'h00);
		wait_present(1);
		rd_chk("rate", IDX_PIXEL_RATE, 32'h02);
		$display("test modes done");
		bus(1, IDX_IRQ_STATUS, 8'h07);
		bus(1, IDX_LOW_LIMIT, 8'h03);
		wait_present(0);
		rd_chk("irq status", IDX_IRQ_STATUS, 32'h02);
		bus(1, IDX_CTRL, 8'h27);
		wait_present(1);
		bus(1, IDX_CTRL, 8'h07);
		bus(1, IDX_LOW_LIMIT, 8'h42);
		$display("test limits done");
		@(posedge i_sys_clk);
		dsi_en <= 0;
		wait_present(0);
		rd_chk("rate", IDX_PIXEL_RATE, 32'h00);
		phy_count = 0;
		@(posedge i_sys_clk);
		dsi_en <= 1;
		wait_present(1);
		chk("phy resets", 0, phy_count);
		$display("test phy mode done");
		end_sim();
	end
endmodule

`default_nettype wire
